// ==== ame_map.svh ====
// Constant map for the matching rule evaluator
`ifndef AME_MAP_SVH
`define AME_MAP_SVH

`define AME_LAYER_OFF       2'h0
`define AME_LAYER_L2        2'h1
`define AME_LAYER_L3        2'h2
`define AME_LAYER_L4        2'h3

`define AME_L2_COUNT        2'h0
`define AME_L2_TYPE         2'h1
`define AME_L2_MAC          2'h2
`define AME_L2_BOTH         2'h3

`define AME_L3_RSVD_LO      2'h0
`define AME_L3_MASKED       2'h1
`define AME_L3_DUAL         2'h2
`define AME_L3_RSVD_HI      2'h3

`define AME_L4_PROTO        2'h0
`define AME_L4_TCP_PORT     2'h1
`define AME_L4_UDP_PORT     2'h2
`define AME_L4_TCP_SEQ      2'h3

`define AME_RANGE_OFF       2'h0
`define AME_RANGE_EITHER    2'h1
`define AME_RANGE_INSIDE    2'h2
`define AME_RANGE_OUTSIDE   2'h3

`define AME_CNT_W           11
`define AME_NUM_PORTS       7
`define AME_PORT_W          3
`define AME_RULES           16
`define AME_RULE_IDX_W      4

`define AME_CLK_PERIOD_NS   4
`define AME_US_NS           1000
`define AME_MS_US           1000
`define AME_US_CYCLES       (`AME_US_NS / `AME_CLK_PERIOD_NS)

`endif

// ==== ame_pkg.sv ====
// Types shared by the matching rule evaluator
`include "ame_map.svh"

package ame_pkg;

  typedef struct packed {
    logic [1:0]  rule_layer_select;
    logic [1:0]  compare_option;
    logic        addr_side;
    logic        match_polarity;
    logic [47:0] mac_addr;
    logic [15:0] ethertype;
    logic [31:0] ip_addr;
    logic [31:0] ip_mask;
    logic [15:0] port_upper;
    logic [15:0] port_lower;
    logic [1:0]  range_check_mode;
    logic [7:0]  ip_transport_code;
    logic        flag_match_on;
    logic [7:0]  flag_ignore_bits;
    logic [7:0]  flag_value;
  } ame_rule_s;

  typedef struct packed {
    logic [1:0] action_priority_mode;
    logic [2:0] priority_value;
    logic       remark_enable_bit;
    logic [2:0] remark_value;
    logic [1:0] map_merge_mode;
    logic       count_unit_sel;
    logic       counter_algorithm;
  } ame_action_s;

  typedef struct packed {
    logic [47:0] dst_mac;
    logic [47:0] src_mac;
    logic [15:0] ethertype;
    logic        is_ipv4;
    logic [31:0] src_ip;
    logic [31:0] dst_ip;
    logic [7:0]  ip_proto;
    logic        is_tcp;
    logic        is_udp;
    logic [15:0] src_port;
    logic [15:0] dst_port;
    logic [31:0] tcp_seq;
    logic [7:0]  tcp_flags;
  } ame_hdr_s;

  typedef enum logic [1:0] {
    AME_CNT_IDLE = 2'b01,
    AME_CNT_RUN  = 2'b10
  } ame_cnt_e;

  typedef struct packed {
    logic                       result;
    logic                       result_valid;
    logic                       group_match;
    logic [`AME_RULE_IDX_W-1:0] group_action;
    logic [`AME_CNT_W-1:0]      cnt;
    ame_cnt_e                   cnt_state;
    logic [`AME_PORT_W-1:0]     port;
    logic [`AME_NUM_PORTS-1:0]  int_status;
    logic                       irq;
  } ame_state_s;

  typedef struct packed {
    logic [15:0] us_cnt;
    logic [15:0] ms_cnt;
    logic        us_tick;
    logic        ms_tick;
  } ame_tick_s;

endpackage

// ==== ame_tick.sv ====
// Microsecond and millisecond tick generator for count mode
`timescale 1ns/1ps
`default_nettype none
`include "ame_map.svh"

module ame_tick #(
  parameter int US_CYCLES = `AME_US_CYCLES,
  parameter int MS_US     = `AME_MS_US
) (
  input  wire logic CLK,
  input  wire logic RST_N,
  output logic      US_TICK,
  output logic      MS_TICK
);

  ame_pkg::ame_tick_s st_r;
  ame_pkg::ame_tick_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.us_tick = 1'b0;
    st_nxt.ms_tick = 1'b0;
    if (st_r.us_cnt == 16'(US_CYCLES - 1)) begin
      st_nxt.us_cnt  = 16'h0000;
      st_nxt.us_tick = 1'b1;
      // Millisecond cascades off microseconds to keep both counters short
      if (st_r.ms_cnt == 16'(MS_US - 1)) begin
        st_nxt.ms_cnt  = 16'h0000;
        st_nxt.ms_tick = 1'b1;
      end else begin
        st_nxt.ms_cnt = st_r.ms_cnt + 16'h0001;
      end
    end else begin
      st_nxt.us_cnt = st_r.us_cnt + 16'h0001;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign US_TICK = st_r.us_tick;
  assign MS_TICK = st_r.ms_tick;

endmodule // ame_tick

`default_nettype wire

// ==== ame_rule_eval.sv ====
// One access-control matching rule with count mode and group combine
`timescale 1ns/1ps
`default_nettype none
`include "ame_map.svh"

module ame_rule_eval #(
  parameter int RULE_INDEX = 0,
  parameter int US_CYCLES  = `AME_US_CYCLES,
  parameter int MS_US      = `AME_MS_US
) (
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  input  wire ame_pkg::ame_rule_s         RULE_CFG,
  input  wire ame_pkg::ame_action_s       ACTION_CFG,
  input  wire logic [`AME_RULES-1:0]      RULE_GROUP_BITS,
  input  wire logic [`AME_RULE_IDX_W-1:0] ACTION_POINTER,
  input  wire logic [`AME_RULES-1:0]      PEER_RESULTS,
  input  wire logic                       FRAME_VALID,
  input  wire ame_pkg::ame_hdr_s          FRAME_HDR,
  input  wire logic [`AME_PORT_W-1:0]     FRAME_PORT,
  input  wire logic [`AME_NUM_PORTS-1:0]  PORT_INT_MASK,
  input  wire logic [`AME_NUM_PORTS-1:0]  PORT_INT_CLEAR,
  output logic                            RULE_RESULT,
  output logic                            RESULT_VALID,
  output logic                            GROUP_MATCH,
  output logic [`AME_RULE_IDX_W-1:0]      GROUP_ACTION,
  output logic [`AME_CNT_W-1:0]           COUNT_NOW,
  output logic [`AME_NUM_PORTS-1:0]       PORT_INT_STATUS,
  output logic                            PORT_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Time base

  logic us_tick;
  logic ms_tick;
  logic unit_tick;

  ame_tick #(
    .US_CYCLES (US_CYCLES),
    .MS_US     (MS_US)
  ) u_tick (
    .CLK     (CLK),
    .RST_N   (RST_N),
    .US_TICK (us_tick),
    .MS_TICK (ms_tick)
  );

  assign unit_tick = ACTION_CFG.count_unit_sel ? ms_tick : us_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Field selection

  logic [47:0]           mac_sel;
  logic [31:0]           ip_sel;
  logic [15:0]           port_sel;
  logic [`AME_CNT_W-1:0] count_value;

  assign mac_sel  = RULE_CFG.addr_side ? FRAME_HDR.src_mac  : FRAME_HDR.dst_mac;
  assign ip_sel   = RULE_CFG.addr_side ? FRAME_HDR.src_ip   : FRAME_HDR.dst_ip;
  assign port_sel = RULE_CFG.addr_side ? FRAME_HDR.src_port : FRAME_HDR.dst_port;

  assign count_value = {ACTION_CFG.action_priority_mode,
                        ACTION_CFG.priority_value,
                        ACTION_CFG.remark_enable_bit,
                        ACTION_CFG.remark_value,
                        ACTION_CFG.map_merge_mode};

  ////////////////////////////////////////////////////////////////////////////
  // Comparisons

  logic type_eq;
  logic mac_eq;
  logic ip_masked_eq;
  logic ip_dual_eq;
  logic in_range;
  logic port_ok;
  logic flag_ok;
  logic seq_eq;
  logic proto_eq;
  logic cond;
  logic rule_live;
  logic rule_hit;
  logic count_mode;

  assign type_eq      = FRAME_HDR.ethertype == RULE_CFG.ethertype;
  assign mac_eq       = mac_sel == RULE_CFG.mac_addr;
  assign ip_masked_eq = ((ip_sel ^ RULE_CFG.ip_addr) & ~RULE_CFG.ip_mask) == 32'h0000_0000;
  assign ip_dual_eq   = (FRAME_HDR.src_ip == RULE_CFG.ip_addr) &&
                        (FRAME_HDR.dst_ip == RULE_CFG.ip_mask);
  assign in_range     = (port_sel >= RULE_CFG.port_lower) && (port_sel <= RULE_CFG.port_upper);
  assign seq_eq       = FRAME_HDR.tcp_seq == {RULE_CFG.port_upper, RULE_CFG.port_lower};
  assign proto_eq     = FRAME_HDR.is_ipv4 &&
                        (FRAME_HDR.ip_proto == RULE_CFG.ip_transport_code);
  // Flags only exist in TCP, so a UDP frame never passes an enabled flag test
  assign flag_ok      = !RULE_CFG.flag_match_on ||
                        (FRAME_HDR.is_tcp &&
                         (((FRAME_HDR.tcp_flags ^ RULE_CFG.flag_value) &
                           ~RULE_CFG.flag_ignore_bits) == 8'h00));
  assign count_mode   = (RULE_CFG.rule_layer_select == `AME_LAYER_L2) &&
                        (RULE_CFG.compare_option == `AME_L2_COUNT);

  always_comb begin
    unique case (RULE_CFG.range_check_mode)
      `AME_RANGE_OFF:    port_ok = 1'b1;
      `AME_RANGE_EITHER: port_ok = (port_sel == RULE_CFG.port_upper) ||
                                   (port_sel == RULE_CFG.port_lower);
      `AME_RANGE_INSIDE: port_ok = in_range;
      default:           port_ok = !in_range;
    endcase
  end

  always_comb begin
    cond      = 1'b0;
    rule_live = 1'b1;
    unique case (RULE_CFG.rule_layer_select)
      `AME_LAYER_OFF: begin
        rule_live = 1'b0;
      end
      `AME_LAYER_L2: begin
        unique case (RULE_CFG.compare_option)
          `AME_L2_TYPE: cond = type_eq;
          `AME_L2_MAC:  cond = mac_eq;
          default:      cond = type_eq && mac_eq;
        endcase
      end
      `AME_LAYER_L3: begin
        unique case (RULE_CFG.compare_option)
          `AME_L3_MASKED: cond = FRAME_HDR.is_ipv4 && ip_masked_eq;
          `AME_L3_DUAL:   cond = FRAME_HDR.is_ipv4 && ip_dual_eq;
          default:        rule_live = 1'b0;
        endcase
      end
      default: begin
        unique case (RULE_CFG.compare_option)
          `AME_L4_PROTO:    cond = proto_eq;
          `AME_L4_TCP_PORT: cond = FRAME_HDR.is_tcp && port_ok && flag_ok;
          `AME_L4_UDP_PORT: cond = FRAME_HDR.is_udp && port_ok;
          default:          cond = FRAME_HDR.is_tcp && seq_eq && flag_ok;
        endcase
      end
    endcase
  end

  assign rule_hit = rule_live && (RULE_CFG.match_polarity ? cond : !cond);

  ////////////////////////////////////////////////////////////////////////////
  // Group combine

  logic [`AME_RULES-1:0] all_results;
  logic                  group_hit;

  always_comb begin
    all_results             = PEER_RESULTS;
    all_results[RULE_INDEX] = rule_hit;
  end

  // An empty group never fires, so an unprogrammed entry stays quiet
  assign group_hit = (RULE_GROUP_BITS != '0) &&
                     (&(all_results | ~RULE_GROUP_BITS));

  ////////////////////////////////////////////////////////////////////////////
  // State update

  ame_pkg::ame_state_s st_r;
  ame_pkg::ame_state_s st_nxt;
  logic                cnt_event;
  logic                cnt_hit;

  assign cnt_hit = FRAME_VALID && count_mode && rule_hit;

  always_comb begin
    st_nxt              = st_r;
    st_nxt.result_valid = 1'b0;
    cnt_event           = 1'b0;
    if (FRAME_VALID) begin
      st_nxt.result       = rule_hit;
      st_nxt.result_valid = 1'b1;
      st_nxt.group_match  = group_hit;
      st_nxt.group_action = ACTION_POINTER;
    end
    if (!count_mode) begin
      st_nxt.cnt       = '0;
      st_nxt.cnt_state = ame_pkg::AME_CNT_IDLE;
    end else if (ACTION_CFG.counter_algorithm) begin
      st_nxt.cnt_state = ame_pkg::AME_CNT_IDLE;
      if (cnt_hit) begin
        st_nxt.port = FRAME_PORT;
        // Tick input ignored here; only frames advance the count
        if (st_r.cnt + `AME_CNT_W'(1) >= count_value) begin
          cnt_event  = 1'b1;
          st_nxt.cnt = '0;
        end else begin
          st_nxt.cnt = st_r.cnt + `AME_CNT_W'(1);
        end
      end
    end else begin
      unique case (st_r.cnt_state)
        ame_pkg::AME_CNT_IDLE: begin
          if (cnt_hit) begin
            st_nxt.port      = FRAME_PORT;
            st_nxt.cnt       = count_value;
            st_nxt.cnt_state = ame_pkg::AME_CNT_RUN;
          end
        end
        ame_pkg::AME_CNT_RUN: begin
          if (cnt_hit) begin
            // A fresh frame beats a tick in the same cycle
            st_nxt.port = FRAME_PORT;
            st_nxt.cnt  = count_value;
          end else if (unit_tick) begin
            if (st_r.cnt <= `AME_CNT_W'(1)) begin
              cnt_event        = 1'b1;
              st_nxt.cnt       = '0;
              st_nxt.cnt_state = ame_pkg::AME_CNT_IDLE;
            end else begin
              st_nxt.cnt = st_r.cnt - `AME_CNT_W'(1);
            end
          end
        end
        default: begin
          st_nxt.cnt       = '0;
          st_nxt.cnt_state = ame_pkg::AME_CNT_IDLE;
        end
      endcase
    end
    // Set wins over a clear landing in the same cycle
    st_nxt.int_status = st_r.int_status & ~PORT_INT_CLEAR;
    if (cnt_event) begin
      st_nxt.int_status[st_nxt.port] = 1'b1;
    end
    st_nxt.irq = |(st_nxt.int_status & ~PORT_INT_MASK);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r           <= '0;
      st_r.cnt_state <= ame_pkg::AME_CNT_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RULE_RESULT     = st_r.result;
  assign RESULT_VALID    = st_r.result_valid;
  assign GROUP_MATCH     = st_r.group_match;
  assign GROUP_ACTION    = st_r.group_action;
  assign COUNT_NOW       = st_r.cnt;
  assign PORT_INT_STATUS = st_r.int_status;
  assign PORT_IRQ        = st_r.irq;

endmodule // ame_rule_eval

`default_nettype wire

// ==== ame_rule_eval_asserts.sv ====
// Port checker for the matching rule evaluator
`timescale 1ns/1ps
`default_nettype none
`include "ame_map.svh"

module ame_rule_eval_asserts (
  input wire logic                       CLK,
  input wire logic                       RST_N,
  input wire ame_pkg::ame_rule_s         RULE_CFG,
  input wire ame_pkg::ame_action_s       ACTION_CFG,
  input wire logic [`AME_RULES-1:0]      RULE_GROUP_BITS,
  input wire logic [`AME_RULE_IDX_W-1:0] ACTION_POINTER,
  input wire logic [`AME_RULES-1:0]      PEER_RESULTS,
  input wire logic                       FRAME_VALID,
  input wire ame_pkg::ame_hdr_s          FRAME_HDR,
  input wire logic [`AME_PORT_W-1:0]     FRAME_PORT,
  input wire logic [`AME_NUM_PORTS-1:0]  PORT_INT_MASK,
  input wire logic [`AME_NUM_PORTS-1:0]  PORT_INT_CLEAR,
  input wire logic                       RULE_RESULT,
  input wire logic                       RESULT_VALID,
  input wire logic                       GROUP_MATCH,
  input wire logic [`AME_RULE_IDX_W-1:0] GROUP_ACTION,
  input wire logic [`AME_CNT_W-1:0]      COUNT_NOW,
  input wire logic [`AME_NUM_PORTS-1:0]  PORT_INT_STATUS,
  input wire logic                       PORT_IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  wire logic cnt_mode = RULE_CFG.rule_layer_select == `AME_LAYER_L2
                        && RULE_CFG.compare_option == `AME_L2_COUNT;
  wire logic l3_rsvd = RULE_CFG.rule_layer_select == `AME_LAYER_L3
                       && (RULE_CFG.compare_option == `AME_L3_RSVD_LO
                           || RULE_CFG.compare_option == `AME_L3_RSVD_HI);

  sequence s_take;
    FRAME_VALID;
  endsequence
  // Counted frame: taken in count mode and answered with a hit
  sequence s_cnt_hit;
    FRAME_VALID && cnt_mode ##1 RESULT_VALID && RULE_RESULT;
  endsequence

  AST_LAT: assert property (s_take |=> RESULT_VALID)
    else $error("no answer one cycle after frame");
  AST_OFF: assert property (s_take ##0 RULE_CFG.rule_layer_select == `AME_LAYER_OFF
    |=> !RULE_RESULT)
    else $error("disabled rule gave a hit");
  AST_RSVD: assert property (s_take ##0 l3_rsvd |=> !RULE_RESULT)
    else $error("reserved option gave a hit");
  AST_HOLD: assert property (!FRAME_VALID |=> !RESULT_VALID && $stable(RULE_RESULT)
    && $stable(GROUP_MATCH))
    else $error("result moved without a frame");
  AST_ACT: assert property (s_take |=> GROUP_ACTION == $past(ACTION_POINTER))
    else $error("group action not captured");
  AST_EMPTY: assert property (s_take ##0 RULE_GROUP_BITS == 16'h0000
    |=> !GROUP_MATCH)
    else $error("empty group matched");
  AST_LOAD: assert property (s_cnt_hit ##0 !ACTION_CFG.counter_algorithm
    |-> COUNT_NOW == {ACTION_CFG.action_priority_mode, ACTION_CFG.priority_value,
    ACTION_CFG.remark_enable_bit, ACTION_CFG.remark_value,
    ACTION_CFG.map_merge_mode})
    else $error("timeout counter not loaded");
  AST_STICKY: assert property (!(|($past(PORT_INT_STATUS) & ~PORT_INT_STATUS
    & ~$past(PORT_INT_CLEAR))))
    else $error("status bit dropped without clear");
  AST_IRQ: assert property (PORT_IRQ |-> |PORT_INT_STATUS)
    else $error("interrupt without status");
endmodule // ame_rule_eval_asserts

bind ame_rule_eval ame_rule_eval_asserts ame_rule_eval_asserts_inst (.*);

`default_nettype wire

// ==== ame_far_model.sv ====
// Ingress parser model that presents one header per request
`timescale 1ns/1ps
`default_nettype none

module ame_far_model (
  input  wire logic              CLK,
  input  wire logic              SEND,
  input  wire ame_pkg::ame_hdr_s HDR_IN,
  input  wire logic [2:0]        PORT_IN,
  output var logic               FRAME_VALID,
  output var ame_pkg::ame_hdr_s  FRAME_HDR,
  output var logic [2:0]         FRAME_PORT
);
  initial begin
    FRAME_VALID = 1'b0;
    FRAME_HDR   = '0;
    FRAME_PORT  = 3'h0;
  end
  // Outside a frame the fields flip so stale data never looks valid
  always @(posedge CLK) begin
    FRAME_VALID <= SEND;
    FRAME_HDR   <= SEND ? HDR_IN : ~FRAME_HDR;
    FRAME_PORT  <= SEND ? PORT_IN : ~FRAME_PORT;
  end
endmodule // ame_far_model

`default_nettype wire

// ==== acl_matching_rule_eval_bench.sv ====
// Self-checking bench for the matching rule evaluator
`timescale 1ns/1ps
`default_nettype none
`include "ame_map.svh"

module acl_matching_rule_eval_bench;
  logic                 clk;
  logic                 rst_n;
  logic                 send;
  logic [15:0]          grp;
  logic [15:0]          peer;
  logic [3:0]           ptr;
  logic [6:0]           msk;
  logic [6:0]           clr;
  ame_pkg::ame_rule_s   cfg;
  ame_pkg::ame_action_s act;
  ame_pkg::ame_hdr_s    h;
  ame_pkg::ame_hdr_s    f_hdr;
  logic                 f_vld;
  logic [2:0]           f_prt;
  logic                 rres;
  logic                 rvld;
  logic                 gm;
  logic [3:0]           ga;
  logic [10:0]          cnow;
  logic [6:0]           ists;
  logic                 irq;
  int                   fails;
  int                   tests_run;
  int                   n;

  always #2 clk = ~clk;

  ame_far_model ame_far_model_inst (
    .CLK        (clk),
    .SEND       (send),
    .HDR_IN     (h),
    .PORT_IN    (3'h3),
    .FRAME_VALID(f_vld),
    .FRAME_HDR  (f_hdr),
    .FRAME_PORT (f_prt)
  );
  // Short tick counts keep timeout runs brief
  ame_rule_eval #(
    .US_CYCLES(4),
    .MS_US    (3)
  ) ame_rule_eval_inst (
    .CLK            (clk),
    .RST_N          (rst_n),
    .RULE_CFG       (cfg),
    .ACTION_CFG     (act),
    .RULE_GROUP_BITS(grp),
    .ACTION_POINTER (ptr),
    .PEER_RESULTS   (peer),
    .FRAME_VALID    (f_vld),
    .FRAME_HDR      (f_hdr),
    .FRAME_PORT     (f_prt),
    .PORT_INT_MASK  (msk),
    .PORT_INT_CLEAR (clr),
    .RULE_RESULT    (rres),
    .RESULT_VALID   (rvld),
    .GROUP_MATCH    (gm),
    .GROUP_ACTION   (ga),
    .COUNT_NOW      (cnow),
    .PORT_INT_STATUS(ists),
    .PORT_IRQ       (irq)
  );

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic to;
    chk("wait limit", 32'h0, 32'h1);
    tally_and_finish();
  endtask
  task automatic rc(input logic [1:0] l, input logic [1:0] o, input logic s, input logic q);
    cfg.rule_layer_select <= l;
    cfg.compare_option <= o;
    cfg.addr_side <= s;
    cfg.match_polarity <= q;
  endtask
  task automatic fr(input string nm, input logic e);
    int i;
    @(posedge clk);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    for (i = 0; i < 8 && rvld !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 8) to();
    chk(nm, {31'h0, rres}, {31'h0, e});
  endtask
  task automatic ws;
    for (n = 0; n < 60 && ists[3] !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 60) to();
  endtask
  task automatic clr3;
    @(posedge clk);
    clr <= 7'h08;
    @(posedge clk);
    clr <= 7'h00;
    @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////
  task automatic t_l2;
    cfg.mac_addr <= h.dst_mac;
    cfg.ethertype <= h.ethertype;
    rc(`AME_LAYER_L2, `AME_L2_MAC, 1'b0, 1'b1);
    fr("l2 dst mac", 1'b1);
    rc(`AME_LAYER_L2, `AME_L2_MAC, 1'b1, 1'b1);
    fr("l2 src mac", 1'b0);
    rc(`AME_LAYER_L2, `AME_L2_MAC, 1'b1, 1'b0);
    fr("l2 unequal", 1'b1);
    rc(`AME_LAYER_L2, `AME_L2_TYPE, 1'b1, 1'b1);
    fr("l2 type", 1'b1);
    cfg.ethertype <= 16'h86DD;
    rc(`AME_LAYER_L2, `AME_L2_BOTH, 1'b0, 1'b1);
    fr("l2 both", 1'b0);
    rc(`AME_LAYER_OFF, `AME_L2_MAC, 1'b0, 1'b0);
    fr("layer off", 1'b0);
    rc(`AME_LAYER_L3, `AME_L3_RSVD_LO, 1'b0, 1'b0);
    fr("l3 rsvd lo", 1'b0);
    rc(`AME_LAYER_L3, `AME_L3_RSVD_HI, 1'b0, 1'b0);
    fr("l3 rsvd hi", 1'b0);
    $display("done l2");
  endtask
  task automatic t_l3;
    cfg.ip_addr <= 32'hC0A8FF02;
    cfg.ip_mask <= 32'h0000FF00;
    rc(`AME_LAYER_L3, `AME_L3_MASKED, 1'b0, 1'b1);
    fr("l3 masked", 1'b1);
    cfg.ip_mask <= 32'h00000000;
    fr("l3 unmasked", 1'b0);
    cfg.ip_addr <= h.src_ip;
    cfg.ip_mask <= h.dst_ip;
    rc(`AME_LAYER_L3, `AME_L3_DUAL, 1'b0, 1'b1);
    fr("l3 dual", 1'b1);
    cfg.ip_mask <= h.src_ip;
    fr("l3 dual bad dst", 1'b0);
    $display("done l3");
  endtask
  task automatic t_l4;
    cfg.ip_transport_code <= 8'h06;
    rc(`AME_LAYER_L4, `AME_L4_PROTO, 1'b0, 1'b1);
    fr("l4 proto", 1'b1);
    cfg.ip_transport_code <= 8'h11;
    fr("l4 proto other", 1'b0);
    cfg.port_upper <= 16'h0050;
    cfg.port_lower <= 16'h0010;
    cfg.range_check_mode <= `AME_RANGE_EITHER;
    rc(`AME_LAYER_L4, `AME_L4_TCP_PORT, 1'b0, 1'b1);
    fr("port either", 1'b1);
    cfg.range_check_mode <= `AME_RANGE_INSIDE;
    fr("port inside", 1'b1);
    cfg.range_check_mode <= `AME_RANGE_OUTSIDE;
    fr("port outside", 1'b0);
    rc(`AME_LAYER_L4, `AME_L4_TCP_PORT, 1'b1, 1'b1);
    fr("src port outside", 1'b1);
    cfg.range_check_mode <= `AME_RANGE_OFF;
    cfg.flag_match_on <= 1'b1;
    cfg.flag_value <= 8'h10;
    cfg.flag_ignore_bits <= 8'h02;
    fr("flags ignored bit", 1'b1);
    cfg.flag_ignore_bits <= 8'h00;
    fr("flags all", 1'b0);
    cfg.flag_match_on <= 1'b0;
    cfg.port_upper <= 16'h1234;
    cfg.port_lower <= 16'h5678;
    rc(`AME_LAYER_L4, `AME_L4_TCP_SEQ, 1'b0, 1'b1);
    fr("tcp seq", 1'b1);
    cfg.port_lower <= 16'h5679;
    fr("tcp seq off", 1'b0);
    rc(`AME_LAYER_L4, `AME_L4_UDP_PORT, 1'b0, 1'b1);
    fr("udp on tcp", 1'b0);
    h.is_tcp <= 1'b0;
    h.is_udp <= 1'b1;
    cfg.port_upper <= 16'h0050;
    cfg.port_lower <= 16'h0010;
    cfg.range_check_mode <= `AME_RANGE_INSIDE;
    fr("udp port", 1'b1);
    h.is_tcp <= 1'b1;
    h.is_udp <= 1'b0;
    $display("done l4");
  endtask
  task automatic t_grp;
    cfg.mac_addr <= h.dst_mac;
    rc(`AME_LAYER_L2, `AME_L2_MAC, 1'b0, 1'b1);
    grp <= 16'h0003;
    peer <= 16'h0002;
    ptr <= 4'hA;
    fr("grp own hit", 1'b1);
    chk("grp and", {31'h0, gm}, 32'h1);
    chk("grp action", {28'h0, ga}, 32'hA);
    peer <= 16'h0000;
    fr("grp own hit", 1'b1);
    chk("grp peer miss", {31'h0, gm}, 32'h0);
    $display("done grp");
  endtask
  task automatic t_cnt;
    cfg.ethertype <= h.ethertype;
    rc(`AME_LAYER_L2, `AME_L2_COUNT, 1'b0, 1'b1);
    act <= '{map_merge_mode: 2'h2, counter_algorithm: 1'b1, default: '0};
    fr("cnt hit", 1'b1);
    chk("cnt one", {21'h0, cnow}, 32'h1);
    fr("cnt hit", 1'b1);
    chk("cnt wrap", {21'h0, cnow}, 32'h0);
    chk("cnt status", {25'h0, ists}, 32'h8);
    chk("cnt irq", {31'h0, irq}, 32'h1);
    msk <= 7'h08;
    // Mask must silence the line while the status bit still stands
    @(posedge clk);
    #1;
    chk("irq masked", {31'h0, irq}, 32'h0);
    chk("status kept", {25'h0, ists}, 32'h8);
    clr3();
    chk("status clear", {25'h0, ists}, 32'h0);
    msk <= 7'h00;
    act <= '{map_merge_mode: 2'h3, default: '0};
    fr("tmo hit", 1'b1);
    chk("tmo load", {21'h0, cnow}, 32'h3);
    for (n = 0; n < 20 && cnow !== 11'h002; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 20) to();
    fr("tmo reload", 1'b1);
    chk("tmo reload", {21'h0, cnow}, 32'h3);
    ws();
    chk("us expiry", {31'h0, n >= 7 && n <= 14}, 32'h1);
    clr3();
    // Millisecond unit must take far longer than the microsecond case
    act <= '{map_merge_mode: 2'h3, count_unit_sel: 1'b1, default: '0};
    fr("ms hit", 1'b1);
    ws();
    chk("ms expiry", {31'h0, n >= 22}, 32'h1);
    $display("done cnt");
  endtask

  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    send = 1'b0;
    cfg = '0;
    act = '0;
    grp = 16'h0000;
    peer = 16'h0000;
    ptr = 4'h0;
    msk = 7'h00;
    clr = 7'h00;
    fails = 0;
    tests_run = 0;
    h = '{dst_mac: 48'h0A0B0C0D0E0F, src_mac: 48'h111213141516, ethertype: 16'h0800,
          is_ipv4: 1'b1, src_ip: 32'hC0A80001, dst_ip: 32'hC0A80102, ip_proto: 8'h06,
          is_tcp: 1'b1, is_udp: 1'b0, src_port: 16'h1F90, dst_port: 16'h0050,
          tcp_seq: 32'h12345678, tcp_flags: 8'h12};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_l2();
    t_l3();
    t_l4();
    t_grp();
    t_cnt();
    tally_and_finish();
  end
endmodule // acl_matching_rule_eval_bench

`default_nettype wire
